//--- rtl/fcpwm_core.v
// four channel pulse width modulation core with shared clock generator
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Notes on behaviour
// - prescaler counter offers master clock divided by 1 through 1024, eleven taps
// - two linear dividers give divided clocks a and b, ratio 1 to 1/255
// - each divider divides its own selected tap by its own factor
// - reset clears both factors and tap selects, stopping both divided clocks
// - at reset or clock gated off only the undivided tap is active
// - each channel has a 16-bit counter stepped by its selected clock
// - per-channel clock select field chooses the source, reset to 0
// - left aligned: count up to period then restart, ending the period
// - center aligned: count up to period then down to 0, double length
// - polarity sets the start level of each period, default low
// - alignment bit per channel, default left aligned
// - output fixed 0 for duty=period pol 0, or duty=0 pol 1
// - output fixed 1 for duty=0 pol 0, or duty=period pol 1
// - duty value sets the counts spent at one level per period
// - polarity and alignment change only while disabled; idle level follows at once
// - period and duty written directly only while the channel is disabled
// - update value held until period end, then loaded to period or duty
// - several enable bits in one command start channels in the same cycle
// - period end sets the channel flag; masked flags raise the interrupt
// - interrupt holds until status read or mask clear; the read clears all flags except a period end in the read cycle
// - mask set by enable command ones, cleared by disable command ones
// - factor 0 stops, 1 passes the tap, 2 to 255 divide it
// - tap select codes 0 to 10 pick two to that power, others reserved
// - enable command ones enable channels, disable command ones disable them
// - channel status shows 1 for enabled, 0 for disabled
`include "fcpwm_defs.vh"

module fcpwm_core (
    // clock and reset
    input  wire         CLK,
    input  wire         RESETN,
    // power manager clock gate, high while the core clock runs
    input  wire         CLOCK_ON,
    // clock generator configuration write
    input  wire         GEN_WE,
    input  wire [31:0]  GEN_DATA,
    // per-channel writes, shared data word
    input  wire [3:0]   CFG_WE,
    input  wire [3:0]   PERIOD_WE,
    input  wire [3:0]   DUTY_WE,
    input  wire [3:0]   UPDATE_WE,
    input  wire [15:0]  WR_DATA,
    // channel enable and disable commands
    input  wire [3:0]   ENABLE_CMD,
    input  wire [3:0]   DISABLE_CMD,
    // interrupt mask commands and status read strobe
    input  wire [3:0]   IRQ_ENABLE_CMD,
    input  wire [3:0]   IRQ_DISABLE_CMD,
    input  wire         STATUS_RD,
    // waveform outputs
    output reg  [3:0]   WAVEFORM_OUTPUT,
    // status outputs
    output reg  [3:0]   CH_ENABLED,
    output reg  [3:0]   IRQ_MASK,
    output reg  [3:0]   IRQ_STATUS,
    output reg          IRQ,
    output reg  [7:0]   DIVIDER_A_FACTOR,
    output reg  [3:0]   DIVIDER_A_TAP_SELECT,
    output reg  [7:0]   DIVIDER_B_FACTOR,
    output reg  [3:0]   DIVIDER_B_TAP_SELECT
);

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    reg  [`FCPWM_PRE_W-1:0]    pre_cnt_ff;
    reg  [7:0]                 div_a_cnt_ff;
    reg  [7:0]                 div_b_cnt_ff;
    wire [`FCPWM_TAP_NUM-1:0]  tap;
    wire                       tap_a;
    wire                       tap_b;
    wire                       divided_clock_a;
    wire                       divided_clock_b;
    wire [12:0]                src_tick;
    wire [3:0]                 eop;
    wire [3:0]                 lvl;
    wire [3:0]                 nxt_enabled;
    wire [3:0]                 nxt_status;
    wire [3:0]                 nxt_mask;

    // ------------------------------------------------------------------------
    // prescaler chain
    // ------------------------------------------------------------------------

    // free running counter, held while the clock is gated off
    always @(posedge CLK) begin
        if (!RESETN) begin
            pre_cnt_ff <= 10'h000;
        end else if (CLOCK_ON) begin
            pre_cnt_ff <= pre_cnt_ff + 10'h001;
        end
    end

    // tap k pulses once every 2^k cycles; tap 0 is the master clock itself
    assign tap[0] = 1'b1;
    genvar k;
    generate
        for (k = 1; k < `FCPWM_TAP_NUM; k = k + 1) begin : g_tap
            assign tap[k] = CLOCK_ON & (&pre_cnt_ff[k-1:0]);
        end
    endgenerate

    // picks a tap by code; reserved codes give no tick
    function tap_pick;
        input [3:0]                sel;
        input [`FCPWM_TAP_NUM-1:0] t;
        begin
            if (sel <= `FCPWM_TAP_MAX) begin
                tap_pick = t[sel];
            end else begin
                tap_pick = 1'b0;
            end
        end
    endfunction

    assign tap_a = tap_pick(DIVIDER_A_TAP_SELECT, tap);
    assign tap_b = tap_pick(DIVIDER_B_TAP_SELECT, tap);

    // ------------------------------------------------------------------------
    // linear dividers
    // ------------------------------------------------------------------------

    // configuration fields, cleared by reset so both divided clocks stop
    always @(posedge CLK) begin
        if (!RESETN) begin
            DIVIDER_A_FACTOR     <= `FCPWM_RST_FACT;
            DIVIDER_A_TAP_SELECT <= `FCPWM_RST_TAP;
            DIVIDER_B_FACTOR     <= `FCPWM_RST_FACT;
            DIVIDER_B_TAP_SELECT <= `FCPWM_RST_TAP;
        end else if (GEN_WE) begin
            DIVIDER_A_FACTOR     <= GEN_DATA[`FCPWM_GEN_FACT_A_LSB +: 8];
            DIVIDER_A_TAP_SELECT <= GEN_DATA[`FCPWM_GEN_TAP_A_LSB +: 4];
            DIVIDER_B_FACTOR     <= GEN_DATA[`FCPWM_GEN_FACT_B_LSB +: 8];
            DIVIDER_B_TAP_SELECT <= GEN_DATA[`FCPWM_GEN_TAP_B_LSB +: 4];
        end
    end

    // a tick leaves every factor-th selected tap; factor 0 never ticks
    assign divided_clock_a = tap_a & (DIVIDER_A_FACTOR != `FCPWM_FACT_OFF) &
                             (div_a_cnt_ff >= DIVIDER_A_FACTOR - 8'h01);
    assign divided_clock_b = tap_b & (DIVIDER_B_FACTOR != `FCPWM_FACT_OFF) &
                             (div_b_cnt_ff >= DIVIDER_B_FACTOR - 8'h01);

    // divider counters, parked at zero while stopped
    always @(posedge CLK) begin
        if (!RESETN || DIVIDER_A_FACTOR == `FCPWM_FACT_OFF) begin
            div_a_cnt_ff <= 8'h00;
        end else if (divided_clock_a) begin
            div_a_cnt_ff <= 8'h00;
        end else if (tap_a) begin
            div_a_cnt_ff <= div_a_cnt_ff + 8'h01;
        end
    end

    always @(posedge CLK) begin
        if (!RESETN || DIVIDER_B_FACTOR == `FCPWM_FACT_OFF) begin
            div_b_cnt_ff <= 8'h00;
        end else if (divided_clock_b) begin
            div_b_cnt_ff <= 8'h00;
        end else if (tap_b) begin
            div_b_cnt_ff <= div_b_cnt_ff + 8'h01;
        end
    end

    // all thirteen source ticks, indexed by channel clock select code
    assign src_tick = {divided_clock_b, divided_clock_a, tap};

    // ------------------------------------------------------------------------
    // channels
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < `FCPWM_CH_NUM; i = i + 1) begin : g_ch
            reg  [15:0] cnt_ff;
            reg         down_ff;
            reg  [15:0] period_value_ff;
            reg  [15:0] duty_value_ff;
            reg  [15:0] upd_ff;
            reg         upd_pend_ff;
            reg  [3:0]  sel_ff;
            reg         align_ff;
            reg         pol_ff;
            reg         tgt_ff;
            wire        tick;
            wire        step;
            wire        left_end;
            wire        center_end;
            wire        away;

            // clock selector; codes above divided clock b give no tick
            assign tick = (sel_ff <= `FCPWM_SEL_DIV_B) ? src_tick[sel_ff] : 1'b0;
            assign step = CH_ENABLED[i] & tick;

            // period end in each alignment
            assign left_end   = ({1'b0, cnt_ff} + 17'h0_0001) >= {1'b0, period_value_ff};
            assign center_end = (period_value_ff == 16'h0000) | (down_ff & (cnt_ff <= 16'h0001));
            assign eop[i]     = step & (align_ff ? center_end : left_end);

            // start level for the first duty counts, then the other level
            assign away   = (cnt_ff >= duty_value_ff) & (duty_value_ff != period_value_ff);
            assign lvl[i] = CH_ENABLED[i] ? (away ? ~pol_ff : pol_ff) : pol_ff;

            // channel configuration; polarity and alignment locked while running
            always @(posedge CLK) begin
                if (!RESETN) begin
                    sel_ff   <= `FCPWM_RST_SEL;
                    align_ff <= 1'b0;
                    pol_ff   <= 1'b0;
                    tgt_ff   <= 1'b0;
                end else if (CFG_WE[i]) begin
                    sel_ff <= WR_DATA[`FCPWM_CFG_SEL_LSB +: 4];
                    tgt_ff <= WR_DATA[`FCPWM_CFG_TGT_BIT];
                    if (!CH_ENABLED[i]) begin
                        align_ff <= WR_DATA[`FCPWM_CFG_ALIGN_BIT];
                        pol_ff   <= WR_DATA[`FCPWM_CFG_POL_BIT];
                    end
                end
            end

            // period and duty: direct while disabled, else through update at period end
            always @(posedge CLK) begin
                if (!RESETN) begin
                    period_value_ff <= `FCPWM_RST_CNT;
                    duty_value_ff   <= `FCPWM_RST_CNT;
                    upd_ff          <= `FCPWM_RST_CNT;
                    upd_pend_ff     <= 1'b0;
                end else begin
                    if (PERIOD_WE[i] && !CH_ENABLED[i]) begin
                        period_value_ff <= WR_DATA;
                    end
                    if (DUTY_WE[i] && !CH_ENABLED[i]) begin
                        duty_value_ff <= WR_DATA;
                    end
                    if (eop[i] && upd_pend_ff) begin
                        if (tgt_ff) begin
                            period_value_ff <= upd_ff;
                        end else begin
                            duty_value_ff <= upd_ff;
                        end
                    end
                    if (UPDATE_WE[i]) begin
                        upd_ff      <= WR_DATA;
                        upd_pend_ff <= 1'b1;
                    end else if (eop[i]) begin
                        upd_pend_ff <= 1'b0;
                    end
                end
            end

            // counter, stopped at zero while disabled
            always @(posedge CLK) begin
                if (!RESETN || !CH_ENABLED[i]) begin
                    cnt_ff  <= 16'h0000;
                    down_ff <= 1'b0;
                end else if (step) begin
                    if (!align_ff) begin
                        cnt_ff <= left_end ? 16'h0000 : cnt_ff + 16'h0001;
                    end else if (period_value_ff == 16'h0000) begin
                        cnt_ff <= 16'h0000;
                    end else if (!down_ff) begin
                        cnt_ff <= cnt_ff + 16'h0001;
                        if (({1'b0, cnt_ff} + 17'h0_0001) >= {1'b0, period_value_ff}) begin
                            down_ff <= 1'b1;
                        end
                    end else begin
                        cnt_ff <= cnt_ff - 16'h0001;
                        if (cnt_ff <= 16'h0001) begin
                            down_ff <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // enables, interrupt flags and outputs
    // ------------------------------------------------------------------------

    // one command word enables its channels together; disable wins on a clash
    assign nxt_enabled = (CH_ENABLED | ENABLE_CMD) & ~DISABLE_CMD;

    // a period end in the read cycle survives the clear
    assign nxt_status = (STATUS_RD ? 4'h0 : IRQ_STATUS) | eop;

    // mask commands, disable wins; the interrupt follows the new mask in the same cycle
    assign nxt_mask = (IRQ_MASK | IRQ_ENABLE_CMD) & ~IRQ_DISABLE_CMD;

    // registered state and outputs
    always @(posedge CLK) begin
        if (!RESETN) begin
            CH_ENABLED      <= `FCPWM_RST_CH;
            IRQ_MASK        <= 4'h0;
            IRQ_STATUS      <= 4'h0;
            IRQ             <= 1'b0;
            WAVEFORM_OUTPUT <= 4'h0;
        end else begin
            CH_ENABLED      <= nxt_enabled;
            IRQ_MASK        <= nxt_mask;
            IRQ_STATUS      <= nxt_status;
            IRQ             <= |(nxt_status & nxt_mask);
            WAVEFORM_OUTPUT <= lvl;
        end
    end

endmodule

//--- rtl/fcpwm_defs.vh
// constants for the four channel pwm core
`ifndef FCPWM_DEFS_VH
`define FCPWM_DEFS_VH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define FCPWM_CH_NUM        4
`define FCPWM_CNT_W         16
`define FCPWM_TAP_NUM       11
`define FCPWM_PRE_W         10

// ----------------------------------------------------------------------------
// clock generator configuration word fields
// ----------------------------------------------------------------------------
`define FCPWM_GEN_FACT_A_LSB 0
`define FCPWM_GEN_TAP_A_LSB  8
`define FCPWM_GEN_FACT_B_LSB 16
`define FCPWM_GEN_TAP_B_LSB  24
`define FCPWM_FACT_OFF       8'h00
`define FCPWM_TAP_MAX        4'hA

// ----------------------------------------------------------------------------
// channel configuration word fields
// ----------------------------------------------------------------------------
`define FCPWM_CFG_SEL_LSB    0
`define FCPWM_CFG_ALIGN_BIT  8
`define FCPWM_CFG_POL_BIT    9
`define FCPWM_CFG_TGT_BIT    10
`define FCPWM_SEL_DIV_A      4'hB
`define FCPWM_SEL_DIV_B      4'hC

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define FCPWM_RST_FACT       8'h00
`define FCPWM_RST_TAP        4'h0
`define FCPWM_RST_SEL        4'h0
`define FCPWM_RST_CNT        16'h0000
`define FCPWM_RST_CH         4'h0

`endif

//--- verification/fcpwm_core_assertions.sv
// concurrent checks on the ports of the pwm core
`timescale 1ns/1ps
module fcpwm_core_assertions (
    // clock and reset
    input wire logic        CLK,
    input wire logic        RESETN,
    // writes and commands
    input wire logic        GEN_WE,
    input wire logic [31:0] GEN_DATA,
    input wire logic [3:0]  CFG_WE,
    input wire logic [3:0]  ENABLE_CMD,
    input wire logic [3:0]  DISABLE_CMD,
    input wire logic [3:0]  IRQ_ENABLE_CMD,
    input wire logic [3:0]  IRQ_DISABLE_CMD,
    input wire logic        STATUS_RD,
    // outputs
    input wire logic [3:0]  WAVEFORM_OUTPUT,
    input wire logic [3:0]  CH_ENABLED,
    input wire logic [3:0]  IRQ_MASK,
    input wire logic [3:0]  IRQ_STATUS,
    input wire logic        IRQ,
    input wire logic [7:0]  DIVIDER_A_FACTOR,
    input wire logic [3:0]  DIVIDER_A_TAP_SELECT,
    input wire logic [7:0]  DIVIDER_B_FACTOR,
    input wire logic [3:0]  DIVIDER_B_TAP_SELECT
);
    logic [31:0] gen_last_ff;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // last generator word, for the readback check
    always @(posedge CLK) gen_last_ff <= GEN_DATA;
    property p_ch_on; (ENABLE_CMD & ~DISABLE_CMD) != 4'h0 |=>
        (CH_ENABLED & $past(ENABLE_CMD & ~DISABLE_CMD)) == $past(ENABLE_CMD & ~DISABLE_CMD); endproperty
    property p_ch_off; DISABLE_CMD != 4'h0 |=> (CH_ENABLED & $past(DISABLE_CMD)) == 4'h0; endproperty
    property p_mask_on; (IRQ_ENABLE_CMD & ~IRQ_DISABLE_CMD) != 4'h0 |=>
        (IRQ_MASK & $past(IRQ_ENABLE_CMD & ~IRQ_DISABLE_CMD)) == $past(IRQ_ENABLE_CMD & ~IRQ_DISABLE_CMD);
    endproperty
    property p_irq_level; IRQ == |(IRQ_STATUS & IRQ_MASK); endproperty
    property p_mask_off; IRQ_DISABLE_CMD != 4'h0 |=> (IRQ_MASK & $past(IRQ_DISABLE_CMD)) == 4'h0; endproperty
    property p_irq_hold; IRQ && !STATUS_RD && IRQ_DISABLE_CMD == 4'h0 |=> IRQ; endproperty
    property p_irq_cause; $rose(IRQ) |-> (IRQ_STATUS & IRQ_MASK) != 4'h0; endproperty
    property p_rd_clear; STATUS_RD && CH_ENABLED == 4'h0 && $past(CH_ENABLED) == 4'h0 |=> IRQ_STATUS == 4'h0;
    endproperty
    property p_idle_hold; (CH_ENABLED == 4'h0 && CFG_WE == 4'h0)[*3] |=> $stable(WAVEFORM_OUTPUT); endproperty
    property p_gen_load; GEN_WE |=> {DIVIDER_B_TAP_SELECT, DIVIDER_B_FACTOR, DIVIDER_A_TAP_SELECT,
        DIVIDER_A_FACTOR} == {gen_last_ff[27:16], gen_last_ff[11:0]}; endproperty
    a_ch_on: assert property (p_ch_on) else $error("channel not enabled");
    a_ch_off: assert property (p_ch_off) else $error("channel not disabled");
    a_mask_on: assert property (p_mask_on) else $error("mask not set");
    a_mask_off: assert property (p_mask_off) else $error("mask not cleared");
    a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without masked flag");
    a_irq_level: assert property (p_irq_level) else $error("interrupt differs from masked flags");
    a_rd_clear: assert property (p_rd_clear) else $error("flags kept after status read");
    a_idle_hold: assert property (p_idle_hold) else $error("idle output moved");
    a_gen_load: assert property (p_gen_load) else $error("generator fields not loaded");
    c_enable: cover property (ENABLE_CMD != 4'h0);
    c_irq: cover property ($rose(IRQ));
    c_read: cover property (STATUS_RD && IRQ);
endmodule

//--- verification/fcpwm_core_tb_top.sv
// self-checking testbench of the pwm core
`timescale 1ns/1ps
module fcpwm_core_tb_top;
    logic clk, resetn, clock_on, gen_we, status_rd, irq, clr;
    logic [31:0] gen_data;
    logic [15:0] wr_data;
    logic [3:0] cfg_we, period_we, duty_we, update_we, en, dis, ien, idis;
    logic [3:0] wave, ch_en, mask, stat, a_tap, b_tap;
    logic [7:0] a_fact, b_fact;
    logic [1:0] mch;
    int high_cnt, rise_cnt, miscompares, samples_checked, err;
    fcpwm_core fcpwm_core_inst (.CLK(clk), .RESETN(resetn), .CLOCK_ON(clock_on), .GEN_WE(gen_we),
        .GEN_DATA(gen_data), .CFG_WE(cfg_we), .PERIOD_WE(period_we), .DUTY_WE(duty_we), .UPDATE_WE(update_we),
        .WR_DATA(wr_data), .ENABLE_CMD(en), .DISABLE_CMD(dis), .IRQ_ENABLE_CMD(ien), .IRQ_DISABLE_CMD(idis),
        .STATUS_RD(status_rd), .WAVEFORM_OUTPUT(wave), .CH_ENABLED(ch_en), .IRQ_MASK(mask), .IRQ_STATUS(stat),
        .IRQ(irq), .DIVIDER_A_FACTOR(a_fact), .DIVIDER_A_TAP_SELECT(a_tap), .DIVIDER_B_FACTOR(b_fact),
        .DIVIDER_B_TAP_SELECT(b_tap));
    fcpwm_load_model fcpwm_load_model_inst (.clk(clk), .clr(clr), .ch(mch), .wave(wave), .high_cnt(high_cnt),
        .rise_cnt(rise_cnt));
    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ------------------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    // one-cycle write strobe then one idle cycle: 0 config, 1 period, 2 duty, 3 update
    task automatic strobe(input int kind, input int ch, input logic [15:0] d);
        wr_data = d;
        case (kind)
            0: cfg_we[ch] = 1'b1;
            1: period_we[ch] = 1'b1;
            2: duty_we[ch] = 1'b1;
            default: update_we[ch] = 1'b1;
        endcase
        @(negedge clk);
        {cfg_we, period_we, duty_we, update_we} = 16'h0000;
        @(negedge clk);
    endtask
    // one-cycle command then one idle cycle: 0 enable, 1 disable, 2 mask set, 3 mask clear
    task automatic cmd(input int kind, input logic [3:0] m);
        case (kind)
            0: en = m;
            1: dis = m;
            2: ien = m;
            default: idis = m;
        endcase
        @(negedge clk);
        {en, dis, ien, idis} = 16'h0000;
        @(negedge clk);
    endtask
    task automatic measure(input int n, input int eh, input int er);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        repeat (n) @(negedge clk);
        check("high cycles", eh, high_cnt);
        check("rising edges", er, rise_cnt);
    endtask
    // configure, enable, measure and disable one channel
    task automatic run(input int ch, input logic [15:0] cfg, input int p, input int d, input int n, input int eh,
                       input int er);
        strobe(0, ch, cfg);
        strobe(1, ch, p[15:0]);
        strobe(2, ch, d[15:0]);
        mch = ch[1:0];
        cmd(0, 4'h1 << ch);
        check("enabled", 4'h1 << ch, ch_en);
        repeat (60) @(negedge clk);
        measure(n, eh, er);
        cmd(1, 4'h1 << ch);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog
    initial begin
        #160000;
        miscompares++;
        print_verdict();
    end
    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        {resetn, gen_we, status_rd, clr, gen_data, wr_data, cfg_we, period_we, duty_we, update_we} = '0;
        {en, dis, ien, idis, mch} = '0;
        clock_on = 1'b1;
        repeat (20) @(negedge clk);
        resetn = 1'b1;
        check("status after reset", 0, {wave, ch_en, mask, stat, irq});
        check("divider after reset", 0, {a_fact, a_tap, b_fact, b_tap});
        gen_data = 32'h0202_0103;
        gen_we = 1'b1;
        @(negedge clk);
        gen_we = 1'b0;
        check("divider fields", 24'h20_2103, {b_tap, b_fact, a_tap, a_fact});
        run(0, 16'h0000, 5, 2, 40, 24, 8);
        run(1, 16'h0003, 3, 1, 240, 160, 10);
        run(2, 16'h0100, 4, 1, 80, 70, 10);
        run(3, 16'h020B, 2, 1, 120, 60, 10);
        run(0, 16'h000C, 2, 1, 160, 80, 10);
        run(1, 16'h0000, 4, 4, 40, 0, 0);
        run(1, 16'h0000, 4, 0, 40, 40, 0);
        run(1, 16'h0200, 4, 4, 40, 40, 0);
        run(1, 16'h0200, 4, 0, 40, 0, 0);
        clock_on = 1'b0;
        run(1, 16'h0003, 3, 1, 240, 0, 0);
        clock_on = 1'b1;
        // two identical channels started by one command
        for (int i = 0; i < 2; i++) begin
            strobe(0, i, 16'h0000);
            strobe(1, i, 16'h0005);
            strobe(2, i, 16'h0002);
        end
        mch = 2'd0;
        cmd(0, 4'h3);
        err = 0;
        repeat (50) begin
            @(negedge clk);
            if (wave[0] !== wave[1]) err++;
        end
        check("synchronous channels", 0, err);
        strobe(2, 0, 16'h0000);
        strobe(0, 0, 16'h0200);
        measure(40, 24, 8);
        strobe(3, 0, 16'h0004);
        repeat (20) @(negedge clk);
        measure(40, 8, 8);
        strobe(0, 0, 16'h0400);
        strobe(3, 0, 16'h0008);
        repeat (30) @(negedge clk);
        measure(80, 40, 10);
        cmd(2, 4'h1);
        cmd(2, 4'h0);
        check("mask", 4'h1, mask);
        repeat (10) @(negedge clk);
        check("interrupt", 6'h23, {stat[0], mask, irq});
        cmd(1, 4'hF);
        check("enabled", 0, ch_en);
        repeat (5) @(negedge clk);
        check("interrupt held", 1, irq);
        status_rd = 1'b1;
        @(negedge clk);
        status_rd = 1'b0;
        repeat (2) @(negedge clk);
        check("status cleared", 0, {stat, irq});
        cmd(3, 4'h1);
        check("mask cleared", 0, mask);
        check("idle level", 0, wave[0]);
        strobe(0, 0, 16'h0200);
        repeat (2) @(negedge clk);
        check("idle polarity", 1, wave[0]);
        // second reset in mid-run clears fields and polarity
        resetn = 1'b0;
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        check("status after second reset", 0, {wave, ch_en, mask, stat, irq});
        check("divider after second reset", 0, {a_fact, a_tap, b_fact, b_tap});
        repeat (2) @(negedge clk);
        check("idle after second reset", 0, wave);
        print_verdict();
    end
endmodule
bind fcpwm_core fcpwm_core_assertions fcpwm_core_assertions_inst (.CLK(CLK), .RESETN(RESETN), .GEN_WE(GEN_WE),
    .GEN_DATA(GEN_DATA), .CFG_WE(CFG_WE), .ENABLE_CMD(ENABLE_CMD), .DISABLE_CMD(DISABLE_CMD),
    .IRQ_ENABLE_CMD(IRQ_ENABLE_CMD), .IRQ_DISABLE_CMD(IRQ_DISABLE_CMD), .STATUS_RD(STATUS_RD),
    .WAVEFORM_OUTPUT(WAVEFORM_OUTPUT), .CH_ENABLED(CH_ENABLED), .IRQ_MASK(IRQ_MASK), .IRQ_STATUS(IRQ_STATUS),
    .IRQ(IRQ), .DIVIDER_A_FACTOR(DIVIDER_A_FACTOR), .DIVIDER_A_TAP_SELECT(DIVIDER_A_TAP_SELECT),
    .DIVIDER_B_FACTOR(DIVIDER_B_FACTOR), .DIVIDER_B_TAP_SELECT(DIVIDER_B_TAP_SELECT));

//--- verification/fcpwm_load_model.sv
// load model on the waveform outputs, counting high cycles and rising edges
`timescale 1ns/1ps
module fcpwm_load_model (
    // clock, count clear and watched channel
    input wire logic       clk,
    input wire logic       clr,
    input wire logic [1:0] ch,
    // waveform outputs of the core
    input wire logic [3:0] wave,
    // measured counts
    output int             high_cnt,
    output int             rise_cnt
);
    logic last_ff;
    // accumulate level and edge counts of the watched channel
    always @(posedge clk) begin
        last_ff <= wave[ch];
        high_cnt <= clr ? 0 : high_cnt + int'(wave[ch]);
        rise_cnt <= clr ? 0 : rise_cnt + int'(wave[ch] & ~last_ff);
    end
endmodule
